// >>> design/adcstc_top.sv
// What this block does
// - Sample and conversion times both come from one timing byte, 8 or 10 bit.
// - Bits 7..5 are sample count; sample clocks equal eight times count plus two.
// - Conversion clocks equal two times resolution times count plus one, plus three.
// - Timing works for every byte value; accuracy only within limits.
// - Test register selects ground or reference input and zero offset trim.
`timescale 1ns/1ps
module adcstc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter front end
    output logic acquire_active,
    output logic resolve_active,
    output logic resolution_ten,
    output logic analog_ground_sel,
    output logic reference_sel,
    output logic zero_offset_trim,
    output logic convert_done
);
    import adcstc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] timing;
        logic [2:0] test;
        logic ten;
        adcstc_state_t st;
        logic [10:0] cnt;
        logic done;
        logic pulse;
        logic ack;
        logic [31:0] rdata;
    } adcstc_regs_t;

    adcstc_regs_t r_q;
    adcstc_regs_t r_d;
    logic [2:0] acq_cnt;
    logic [4:0] res_cnt;
    logic [10:0] acq_len;
    logic [10:0] res_len;
    logic [4:0] bits;
    logic access;

    // Field split, conversion count in bits 4..0
    assign acq_cnt = r_q.timing[7:ADCSTC_ACQ_LSB];
    assign res_cnt = r_q.timing[ADCSTC_RES_MSB:0];
    assign bits = r_q.ten ? ADCSTC_BITS_10 : ADCSTC_BITS_8;
    // Phase lengths for any byte value, widths cover the maxima
    assign acq_len = 11'({3'h0, ADCSTC_ACQ_MUL} * {8'h00, acq_cnt}) + 11'(ADCSTC_ACQ_ADD);
    assign res_len = 11'(11'({6'h00, bits}) * 11'({6'h00, res_cnt} + 11'h001) * 11'h002)
                     + ADCSTC_RES_ADD;
    assign access = (avs_read | avs_write) & ~r_q.ack;

    // Next state
    always_comb begin
        r_d = r_q;
        r_d.ack = access;
        r_d.pulse = 1'b0;
        if (avs_write && access) begin
            case (avs_address)
                ADCSTC_OFS_TIMING: begin
                    r_d.timing = avs_writedata[7:0];
                end
                ADCSTC_OFS_TEST: begin
                    r_d.test = avs_writedata[2:0];
                end
                ADCSTC_OFS_CTRL: begin
                    r_d.ten = avs_writedata[ADCSTC_CTL_TEN];
                    r_d.pulse = avs_writedata[ADCSTC_CTL_START];
                end
                default: begin
                end
            endcase
        end
        if (avs_read && access) begin
            case (avs_address)
                ADCSTC_OFS_TIMING: r_d.rdata = {24'h0000_00, r_q.timing};
                ADCSTC_OFS_TEST: r_d.rdata = {29'h0000_0000, r_q.test};
                ADCSTC_OFS_CTRL: r_d.rdata = {30'h0000_0000, r_q.ten, 1'b0};
                ADCSTC_OFS_STATUS: r_d.rdata = {28'h0000_000, r_q.done,
                                               r_q.st == ADCSTC_RES, r_q.st == ADCSTC_ACQ,
                                               r_q.st != ADCSTC_IDLE};
                default: r_d.rdata = 32'h0000_0000;
            endcase
        end
        // Reading status clears done; a new completion wins
        if (avs_read && access && avs_address == ADCSTC_OFS_STATUS) begin
            r_d.done = 1'b0;
        end
        // Sequencer: sample phase, then conversion phase
        case (r_q.st)
            ADCSTC_IDLE: begin
                if (r_q.pulse) begin
                    r_d.st = ADCSTC_ACQ;
                    r_d.cnt = acq_len - 11'h001;
                end
            end
            ADCSTC_ACQ: begin
                if (r_q.cnt == 11'h000) begin
                    r_d.st = ADCSTC_RES;
                    r_d.cnt = res_len - 11'h001;
                end else begin
                    r_d.cnt = r_q.cnt - 11'h001;
                end
            end
            ADCSTC_RES: begin
                if (r_q.cnt == 11'h000) begin
                    r_d.st = ADCSTC_DONE;
                end else begin
                    r_d.cnt = r_q.cnt - 11'h001;
                end
            end
            ADCSTC_DONE: begin
                r_d.st = ADCSTC_IDLE;
                r_d.done = 1'b1;
            end
            default: r_d.st = ADCSTC_IDLE;
        endcase
    end

    // Register the state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '{timing: ADCSTC_TIMING_RST, test: ADCSTC_TEST_RST, ten: 1'b0,
                     st: ADCSTC_IDLE, cnt: 11'h000, done: 1'b0, pulse: 1'b0,
                     ack: 1'b0, rdata: 32'h0000_0000};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~r_q.ack;
    assign avs_readdata = r_q.rdata;
    assign acquire_active = r_q.st == ADCSTC_ACQ;
    assign resolve_active = r_q.st == ADCSTC_RES;
    assign resolution_ten = r_q.ten;
    assign analog_ground_sel = r_q.test[ADCSTC_TST_GND];
    assign reference_sel = r_q.test[ADCSTC_TST_REF];
    assign zero_offset_trim = r_q.test[ADCSTC_TST_ZOFS];
    assign convert_done = r_q.done;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    int acq_run;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acq_run <= 0;
        end else if (r_q.st == ADCSTC_ACQ) begin
            acq_run <= acq_run + 1;
        end else begin
            acq_run <= 0;
        end
    end

    sequence s_acq_end;
        r_q.st == ADCSTC_ACQ ##1 r_q.st == ADCSTC_RES;
    endsequence

    a_acq_length: assert property (@(posedge clk) disable iff (!reset_n)
        s_acq_end |-> ($past(acq_run) + 1) == 32'($past(acq_len)))
        else $error("sample phase length wrong");
    a_start_acq: assert property (@(posedge clk) disable iff (!reset_n)
        (r_q.st == ADCSTC_IDLE && r_q.pulse) |=> r_q.st == ADCSTC_ACQ)
        else $error("start did not enter sample phase");
    a_res_load: assert property (@(posedge clk) disable iff (!reset_n)
        s_acq_end |-> r_q.cnt == res_len - 11'h001)
        else $error("conversion count load wrong");
    a_done_set: assert property (@(posedge clk) disable iff (!reset_n)
        (r_q.st == ADCSTC_RES && r_q.cnt == 11'h000) |=> ##1 convert_done)
        else $error("done not raised");
    a_field_split: assert property (@(posedge clk) disable iff (!reset_n)
        s_acq_end |-> 32'(r_q.cnt) == 2 * int'(r_q.ten ? ADCSTC_BITS_10 : ADCSTC_BITS_8)
            * (int'(r_q.timing[4:0]) + 1) + int'(ADCSTC_RES_ADD) - 1)
        else $error("conversion count not taken from bits 4..0");
    a_test_sel: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_write && access && avs_address == ADCSTC_OFS_TEST)
        |=> analog_ground_sel == $past(avs_writedata[0]))
        else $error("test select not applied");
    a_timing_wr: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_write && access && avs_address == ADCSTC_OFS_TIMING)
        |=> r_q.timing == $past(avs_writedata[7:0]))
        else $error("timing byte not stored");
    a_acq_bound: assert property (@(posedge clk) disable iff (!reset_n)
        acquire_active |-> acq_run < 64)
        else $error("sample phase overran");

    // ----------------------------------------
    // Conversion phase checks
    // ----------------------------------------
    // Cycles spent so far in the conversion phase
    int res_run;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            res_run <= 0;
        end else if (r_q.st == ADCSTC_RES) begin
            res_run <= res_run + 1;
        end else begin
            res_run <= 0;
        end
    end

    // Last conversion clock, then the one-cycle done state
    sequence s_res_end;
        r_q.st == ADCSTC_RES ##1 r_q.st == ADCSTC_DONE;
    endsequence

    // Conversion length, longest legal run and steady countdown
    a_res_formula: assert property (@(posedge clk) disable iff (!reset_n)
        s_res_end |-> ($past(res_run) + 1)
            == 2 * int'(r_q.ten ? ADCSTC_BITS_10 : ADCSTC_BITS_8)
            * (int'(r_q.timing[4:0]) + 1) + int'(ADCSTC_RES_ADD))
        else $error("conversion phase length wrong");
    a_res_bound: assert property (@(posedge clk) disable iff (!reset_n)
        resolve_active |-> res_run < 2 * int'(ADCSTC_BITS_10) * 32 + int'(ADCSTC_RES_ADD))
        else $error("conversion phase overran");
    a_res_count: assert property (@(posedge clk) disable iff (!reset_n)
        (r_q.st == ADCSTC_RES && r_q.cnt != 11'h000)
        |=> r_q.st == ADCSTC_RES && r_q.cnt == $past(r_q.cnt) - 11'h001)
        else $error("conversion countdown wrong");

    // ----------------------------------------
    // Sample phase checks
    // ----------------------------------------
    // Sample length straight from bits 7..5, and a steady countdown
    a_acq_formula: assert property (@(posedge clk) disable iff (!reset_n)
        s_acq_end |-> ($past(acq_run) + 1)
            == int'(ADCSTC_ACQ_MUL) * int'(r_q.timing[7:5]) + int'(ADCSTC_ACQ_ADD))
        else $error("sample phase formula wrong");
    a_acq_count: assert property (@(posedge clk) disable iff (!reset_n)
        (r_q.st == ADCSTC_ACQ && r_q.cnt != 11'h000)
        |=> r_q.st == ADCSTC_ACQ && r_q.cnt == $past(r_q.cnt) - 11'h001)
        else $error("sample countdown wrong");

    // ----------------------------------------
    // Sequencer checks
    // ----------------------------------------
    // Start bit written while idle
    sequence s_start_req;
        avs_write && access && avs_address == ADCSTC_OFS_CTRL
            && avs_writedata[ADCSTC_CTL_START] && r_q.st == ADCSTC_IDLE;
    endsequence

    // Start reaches the sample phase two clocks after the write
    a_start_path: assert property (@(posedge clk) disable iff (!reset_n)
        s_start_req |=> ##1 acquire_active)
        else $error("start write did not begin sampling");
    a_idle_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (r_q.st == ADCSTC_IDLE && !r_q.pulse) |=> r_q.st == ADCSTC_IDLE)
        else $error("sequencer left idle without start");
    a_done_one: assert property (@(posedge clk) disable iff (!reset_n)
        r_q.st == ADCSTC_DONE |=> r_q.st == ADCSTC_IDLE)
        else $error("done state lasted too long");

    // Completion sets the flag even against a status read; a plain read clears it
    a_done_wins: assert property (@(posedge clk) disable iff (!reset_n)
        r_q.st == ADCSTC_DONE |=> convert_done)
        else $error("completion lost");
    a_done_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read && access && avs_address == ADCSTC_OFS_STATUS && r_q.st != ADCSTC_DONE)
        |=> !convert_done)
        else $error("status read did not clear done");

    // ----------------------------------------
    // Register bus checks
    // ----------------------------------------
    // One wait cycle, then the answer
    a_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("more than one wait cycle");

    // Read data reflects the addressed register
    a_read_timing: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read && access && avs_address == ADCSTC_OFS_TIMING)
        |=> avs_readdata == {24'h0000_00, $past(r_q.timing)})
        else $error("timing byte read wrong");
    a_read_test: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read && access && avs_address == ADCSTC_OFS_TEST)
        |=> avs_readdata == {29'h0000_0000, $past(r_q.test)})
        else $error("test register read wrong");
    a_read_ctrl: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read && access && avs_address == ADCSTC_OFS_CTRL)
        |=> avs_readdata == {30'h0000_0000, $past(r_q.ten), 1'b0})
        else $error("control read wrong");
    a_read_done: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read && access && avs_address == ADCSTC_OFS_STATUS)
        |=> avs_readdata[3] == $past(convert_done))
        else $error("done bit read wrong");

    // Writes land in the next clock; other clocks leave the test pins alone
    a_ten_wr: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_write && access && avs_address == ADCSTC_OFS_CTRL)
        |=> resolution_ten == $past(avs_writedata[ADCSTC_CTL_TEN]))
        else $error("ten-bit mode not stored");
    a_test_rest: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_write && access && avs_address == ADCSTC_OFS_TEST)
        |=> reference_sel == $past(avs_writedata[ADCSTC_TST_REF])
            && zero_offset_trim == $past(avs_writedata[ADCSTC_TST_ZOFS]))
        else $error("reference or trim select not applied");
    a_test_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(avs_write && access && avs_address == ADCSTC_OFS_TEST)
        |=> $stable({analog_ground_sel, reference_sel, zero_offset_trim}))
        else $error("test pins changed without a write");
endmodule

// >>> common/adcstc_pkg.sv
package adcstc_pkg;
    // ----------------------------------------
    // Register map (word offsets as bytes)
    // ----------------------------------------
    localparam logic [3:0] ADCSTC_OFS_TIMING = 4'h0;
    localparam logic [3:0] ADCSTC_OFS_TEST = 4'h4;
    localparam logic [3:0] ADCSTC_OFS_CTRL = 4'h8;
    localparam logic [3:0] ADCSTC_OFS_STATUS = 4'hC;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int ADCSTC_ACQ_LSB = 5;
    localparam int ADCSTC_RES_MSB = 4;
    localparam logic [7:0] ADCSTC_TIMING_RST = 8'h00;
    localparam logic [2:0] ADCSTC_TEST_RST = 3'h0;
    // Test register: bit0 ground, bit1 reference, bit2 zero offset trim
    localparam int ADCSTC_TST_GND = 0;
    localparam int ADCSTC_TST_REF = 1;
    localparam int ADCSTC_TST_ZOFS = 2;
    // Ctrl: bit0 start (write pulse), bit1 ten-bit mode
    localparam int ADCSTC_CTL_START = 0;
    localparam int ADCSTC_CTL_TEN = 1;
    // ----------------------------------------
    // Timing constants in oscillator clocks
    // ----------------------------------------
    localparam logic [7:0] ADCSTC_ACQ_MUL = 8'h08;
    localparam logic [7:0] ADCSTC_ACQ_ADD = 8'h02;
    localparam logic [4:0] ADCSTC_BITS_8 = 5'h08;
    localparam logic [4:0] ADCSTC_BITS_10 = 5'h0A;
    localparam logic [10:0] ADCSTC_RES_ADD = 11'h003;
    // ----------------------------------------
    // Sequencer states (Gray along the path)
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCSTC_IDLE = 2'b00,
        ADCSTC_ACQ = 2'b01,
        ADCSTC_RES = 2'b11,
        ADCSTC_DONE = 2'b10
    } adcstc_state_t;
endpackage

// >>> tb/adcstc_front_model.sv
`timescale 1ns/1ps
module adcstc_front_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Phase strobes from the timing block
    input wire logic acquire_active,
    input wire logic resolve_active,
    // Measured phase lengths in clocks
    output logic [15:0] acq_len,
    output logic [15:0] res_len
);
    logic [15:0] acq_cnt;
    logic [15:0] res_cnt;
    // Sample and resolve phases measured, latched when each phase ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {acq_cnt, res_cnt, acq_len, res_len} <= '0;
        end else begin
            acq_cnt <= acquire_active ? acq_cnt + 16'h0001 : 16'h0000;
            res_cnt <= resolve_active ? res_cnt + 16'h0001 : 16'h0000;
            if (!acquire_active && acq_cnt != 16'h0000) acq_len <= acq_cnt;
            if (!resolve_active && res_cnt != 16'h0000) res_len <= res_cnt;
        end
    end
endmodule

// >>> tb/adc_sample_convert_timing_bench.sv
`timescale 1ns/1ps
module adc_sample_convert_timing_bench;
    import adcstc_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, acquire_active, resolve_active, resolution_ten;
    logic analog_ground_sel, reference_sel, zero_offset_trim, convert_done;
    logic [15:0] acq_len, res_len;
    int errors = 0;
    int checks_done = 0;
    // Clock
    always #10 clk = ~clk;
    adcstc_top u_adcstc_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .acquire_active(acquire_active), .resolve_active(resolve_active),
        .resolution_ten(resolution_ten), .analog_ground_sel(analog_ground_sel),
        .reference_sel(reference_sel), .zero_offset_trim(zero_offset_trim),
        .convert_done(convert_done));
    adcstc_front_model u_adcstc_front_model (.clk(clk), .reset_n(reset_n),
        .acquire_active(acquire_active), .resolve_active(resolve_active),
        .acq_len(acq_len), .res_len(res_len));
    // ----------------------------------------
    // Reporting and compares
    // ----------------------------------------
    task final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_len(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // ----------------------------------------
    // Avalon-MM transfer, held until waitrequest low
    // ----------------------------------------
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        logic busy;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        busy = 1'b1;
        do begin
            // Settled answer, as it stands at the coming rising edge
            @(negedge clk);
            busy = avs_waitrequest;
            rd = avs_readdata;
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 50);
        if (busy !== 1'b0) begin
            errors++;
            final_report();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Start one conversion and measure both phases
    task run(input logic [7:0] tb, input logic ten);
        int n;
        bus(1'b1, ADCSTC_OFS_TIMING, {24'h00_0000, tb});
        bus(1'b1, ADCSTC_OFS_CTRL, {30'h0000_0000, ten, 1'b1});
        n = 0;
        // No bus traffic while converting; done looked at away from the edge
        while (convert_done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (convert_done !== 1'b1) begin
            errors++;
            final_report();
        end
        check_len("sample clocks", 16'(8 * tb[7:5] + 2), acq_len);
        check_len("convert clocks", 16'(2 * (ten ? 10 : 8) * (tb[4:0] + 1) + 3),
            res_len);
        check_reg("ten mode", {31'h0000_0000, ten}, {31'h0000_0000, resolution_ten});
        bus(1'b0, ADCSTC_OFS_CTRL, 32'h0000_0000);
        check_reg("ctrl readback", {30'h0000_0000, ten, 1'b0}, rd);
        bus(1'b0, ADCSTC_OFS_STATUS, 32'h0000_0000);
        check_reg("done flag", 32'h0000_0008, rd);
        bus(1'b0, ADCSTC_OFS_STATUS, 32'h0000_0000);
        check_reg("done cleared", 32'h0000_0000, {rd[3], convert_done});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, ADCSTC_OFS_TIMING, 32'h0000_0000);
        check_reg("timing reset", {24'h00_0000, ADCSTC_TIMING_RST}, rd);
        bus(1'b0, ADCSTC_OFS_TEST, 32'h0000_0000);
        check_reg("test reset", 32'h0000_0000, rd);
        bus(1'b1, ADCSTC_OFS_TIMING, 32'hFFFF_FF5A);
        bus(1'b0, ADCSTC_OFS_TIMING, 32'h0000_0000);
        check_reg("timing byte", 32'h0000_005A, rd);
        bus(1'b0, 4'h2, 32'h0000_0000);
        check_reg("unmapped read", 32'h0000_0000, rd);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ADCSTC_OFS_TEST, 32'(1 << i));
            check_reg("test pins", 32'(1 << i),
                {29'h0000_0000, zero_offset_trim, reference_sel, analog_ground_sel});
        end
        run(8'h22, 1'b0);
        run(8'hFF, 1'b1);
        run(8'h00, 1'b0);
        run(8'hE2, 1'b1);
        final_report();
    end
endmodule
